// ---- core/bmh_pkg.sv ----
/*
 * Constants, types and carriers for the bus monitor host register bank.
 * Assumes a single 100 MHz clock domain; all inputs come from logic
 * on that same clock.
 */
// What this block does
// - Address list base is read-write, 16 bits, loads 0x00B0 on master reset
// - Monitor soft reset leaves the address list base untouched
// - Last-message pointer is read-only, loads first stack word at message end
// - Both message pointers clear on master reset and on soft reset
// - Next pointer copies stack current pointer at message end; zero means start
// - Configuration 11 gives a 16-bit count held in the low register
// - Configuration 01 gives a 48-bit count over low, mid and high registers
// - Count bits 15-0 low, 31-16 mid, upper bits high
// - Count ignores writes; clear, capture, load via config bits 15-14
// - Three utility registers are read-write and clear on master reset
// - Load or clear copies utility into count, all three words in 48-bit mode
// - Capture copies count into utility, all three words in 48-bit mode
// - Time-match enable bit 6 raises interrupt on count equal to match
// - Events with enable clear are dropped; later enabling recalls nothing
// - Enabled event sets same pending bit and adds an interrupt log entry
// - Reading a pending register returns it and clears its own bits; hardware summary bits 2-0 still follow their groups
// - Interrupt output asserts only for pending bits with output enable set
// - One interrupt output ORs all output-enabled pending groups
// - Hardware pending bits 2-0 flag non-zero group pending; monitor at bit 1
// - Log keeps 32 entries of two words, ID then address, at 0x0180-0x01BF
// - Monitor bits: 8 cmd roll, 7 data roll, 6/5 matches, 4 error, 3 end
// - Monitor bits 2-0 unwritable, read 000; pending bits 15-9 read 0
package bmh_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_HW_PEND = 8'h06;
    localparam logic [7:0] OFS_MT_PEND = 8'h08;
    localparam logic [7:0] OFS_HW_IE = 8'h0F;
    localparam logic [7:0] OFS_MT_IE = 8'h11;
    localparam logic [7:0] OFS_HW_OE = 8'h13;
    localparam logic [7:0] OFS_MT_OE = 8'h15;
    localparam logic [7:0] OFS_BASE = 8'h2F;
    localparam logic [7:0] OFS_NEXT_PTR = 8'h30;
    localparam logic [7:0] OFS_LAST_PTR = 8'h31;
    localparam logic [7:0] OFS_TT_CFG = 8'h39;
    localparam logic [7:0] OFS_CNT_LO = 8'h3A;
    localparam logic [7:0] OFS_CNT_MID = 8'h3B;
    localparam logic [7:0] OFS_CNT_HI = 8'h3C;
    localparam logic [7:0] OFS_UTIL_LO = 8'h3D;
    localparam logic [7:0] OFS_UTIL_MID = 8'h3E;
    localparam logic [7:0] OFS_UTIL_HI = 8'h3F;
    localparam logic [7:0] OFS_MATCH_LO = 8'h40;
    localparam logic [7:0] OFS_MATCH_MID = 8'h41;
    localparam logic [7:0] OFS_MATCH_HI = 8'h42;

    ////////////////////////////////////////////////////////////////////////
    // Reset values, fields, encodings
    localparam logic [15:0] BASE_RESET = 16'h00B0;
    localparam int HW_TM_BIT = 6;
    localparam int SUM_BC_BIT = 0;
    localparam int SUM_MT_BIT = 1;
    localparam int SUM_RT_BIT = 2;
    localparam int IIW_TM_BIT = 15;
    localparam logic [1:0] MODE_16 = 2'h3;
    localparam logic [1:0] MODE_48 = 2'h1;
    localparam logic [1:0] TT_CLEAR = 2'h1;
    localparam logic [1:0] TT_LOAD = 2'h2;
    localparam logic [1:0] TT_CAPTURE = 2'h3;
    localparam logic [15:0] LOG_BASE = 16'h0180;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef enum logic [0:0] {
        LOG_IDLE = 1'b0,
        LOG_ADDR = 1'b1
    } bmh_log_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bmh_bus_s;

    // Monitor engine side; events use bits 8-3 of the monitor layout
    typedef struct packed {
        logic msg_done;
        logic [15:0] first_addr;
        logic [15:0] stack_ptr;
        logic [8:3] events;
        logic [15:0] status_addr;
        logic tick;
        logic soft_reset;
        logic [1:0] mode;
    } bmh_mon_s;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] data;
    } bmh_log_s;

    typedef struct packed {
        logic [15:0] base;
        logic [15:0] next_ptr;
        logic [15:0] last_ptr;
        logic [13:0] tt_cfg;
        logic [47:0] cnt;
        logic [47:0] util;
        logic [47:0] match;
        logic match_q;
        logic [15:0] hw_ie;
        logic [15:0] hw_oe;
        logic tm_pend;
        logic [8:3] mt_ie;
        logic [8:3] mt_oe;
        logic [8:3] mt_pend;
        logic [15:0] log_id;
        logic [15:0] log_iaw;
        logic [15:0] cur_iaw;
        logic [4:0] log_ptr;
        bmh_log_e log_st;
        bmh_log_s log;
        logic [15:0] rdata;
        logic irq_n;
    } bmh_state_s;

endpackage : bmh_pkg

// ---- core/bmh_regs.sv ----
/*
 * Host register bank of the simple bus monitor: pointers, time tag,
 * monitor interrupts, summary decoding and the interrupt log writer.
 * Assumes the monitor engine, the time base and the other interrupt
 * groups run on i_clk; the host bus reads data one cycle after i_bus.rd.
 */
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module bmh_regs (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire bmh_pkg::bmh_bus_s i_bus,
    input wire bmh_pkg::bmh_mon_s i_mon,
    input wire logic i_bc_pend_nz,
    input wire logic i_rt_pend_nz,
    input wire logic i_bc_irq,
    input wire logic i_rt_irq,
    output logic [15:0] o_rdata,
    output logic o_irq_n,
    output bmh_pkg::bmh_log_s o_log
);

    bmh_pkg::bmh_state_s s_reg;
    bmh_pkg::bmh_state_s s_next;

    function automatic logic wr_hit(input bmh_pkg::bmh_bus_s b,
                                    input logic [7:0] ofs);
        wr_hit = b.wr && (b.addr == ofs);
    endfunction : wr_hit

    function automatic logic rd_hit(input bmh_pkg::bmh_bus_s b,
                                    input logic [7:0] ofs);
        rd_hit = b.rd && (b.addr == ofs);
    endfunction : rd_hit

    logic mode48;
    logic tm_equal;
    logic tm_event;
    logic [8:3] mt_new;
    logic [1:0] tt_cmd;
    logic [15:0] hw_pend_view;

    assign mode48 = (i_mon.mode == bmh_pkg::MODE_48);
    assign tm_equal = mode48 ? (s_reg.cnt == s_reg.match)
                             : (s_reg.cnt[15:0] == s_reg.match[15:0]);
    assign tm_event = tm_equal && !s_reg.match_q
                      && s_reg.hw_ie[bmh_pkg::HW_TM_BIT];
    assign mt_new = i_mon.events & s_reg.mt_ie;
    assign tt_cmd = wr_hit(i_bus, bmh_pkg::OFS_TT_CFG) ? i_bus.wdata[15:14]
                                                       : 2'h0;
    always_comb begin
        hw_pend_view = 16'h0000;
        hw_pend_view[bmh_pkg::HW_TM_BIT] = s_reg.tm_pend;
        hw_pend_view[bmh_pkg::SUM_BC_BIT] = i_bc_pend_nz;
        hw_pend_view[bmh_pkg::SUM_MT_BIT] = |s_reg.mt_pend;
        hw_pend_view[bmh_pkg::SUM_RT_BIT] = i_rt_pend_nz;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.log.we = 1'b0;
        s_next.rdata = 16'h0000;

        // Writable registers
        if (wr_hit(i_bus, bmh_pkg::OFS_BASE)) begin
            s_next.base = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_TT_CFG)) begin
            s_next.tt_cfg = i_bus.wdata[13:0];
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_UTIL_LO)) begin
            s_next.util[15:0] = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_UTIL_MID)) begin
            s_next.util[31:16] = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_UTIL_HI)) begin
            s_next.util[47:32] = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_MATCH_LO)) begin
            s_next.match[15:0] = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_MATCH_MID)) begin
            s_next.match[31:16] = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_MATCH_HI)) begin
            s_next.match[47:32] = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_HW_IE)) begin
            s_next.hw_ie = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_HW_OE)) begin
            s_next.hw_oe = i_bus.wdata;
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_MT_IE)) begin
            s_next.mt_ie = i_bus.wdata[8:3];
        end
        if (wr_hit(i_bus, bmh_pkg::OFS_MT_OE)) begin
            s_next.mt_oe = i_bus.wdata[8:3];
        end

        // Message completion; soft reset leaves the base alone
        if (i_mon.soft_reset) begin
            s_next.next_ptr = 16'h0000;
            s_next.last_ptr = 16'h0000;
        end else if (i_mon.msg_done) begin
            s_next.last_ptr = i_mon.first_addr;
            s_next.next_ptr = i_mon.stack_ptr;
        end

        // Time tag; a load or clear outranks a tick in the same cycle
        if (tt_cmd == bmh_pkg::TT_CLEAR || tt_cmd == bmh_pkg::TT_LOAD) begin
            s_next.cnt[15:0] = s_reg.util[15:0];
            if (mode48) begin
                s_next.cnt[47:16] = s_reg.util[47:16];
            end
        end else begin
            if (tt_cmd == bmh_pkg::TT_CAPTURE) begin
                s_next.util[15:0] = s_reg.cnt[15:0];
                if (mode48) begin
                    s_next.util[47:16] = s_reg.cnt[47:16];
                end
            end
            if (i_mon.tick) begin
                if (mode48) begin
                    s_next.cnt = s_reg.cnt + 48'h1;
                end else begin
                    s_next.cnt[15:0] = s_reg.cnt[15:0] + 16'h1;
                end
            end
        end
        s_next.match_q = tm_equal;

        // Read data and read-to-clear; a new event wins over the clear
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                bmh_pkg::OFS_HW_PEND: s_next.rdata = hw_pend_view;
                bmh_pkg::OFS_MT_PEND: s_next.rdata = {7'h00, s_reg.mt_pend,
                                                      3'h0};
                bmh_pkg::OFS_HW_IE: s_next.rdata = s_reg.hw_ie;
                bmh_pkg::OFS_MT_IE: s_next.rdata = {7'h00, s_reg.mt_ie, 3'h0};
                bmh_pkg::OFS_HW_OE: s_next.rdata = s_reg.hw_oe;
                bmh_pkg::OFS_MT_OE: s_next.rdata = {7'h00, s_reg.mt_oe, 3'h0};
                bmh_pkg::OFS_BASE: s_next.rdata = s_reg.base;
                bmh_pkg::OFS_NEXT_PTR: s_next.rdata = s_reg.next_ptr;
                bmh_pkg::OFS_LAST_PTR: s_next.rdata = s_reg.last_ptr;
                bmh_pkg::OFS_TT_CFG: s_next.rdata = {2'h0, s_reg.tt_cfg};
                bmh_pkg::OFS_CNT_LO: s_next.rdata = s_reg.cnt[15:0];
                bmh_pkg::OFS_CNT_MID: s_next.rdata = s_reg.cnt[31:16];
                bmh_pkg::OFS_CNT_HI: s_next.rdata = s_reg.cnt[47:32];
                bmh_pkg::OFS_UTIL_LO: s_next.rdata = s_reg.util[15:0];
                bmh_pkg::OFS_UTIL_MID: s_next.rdata = s_reg.util[31:16];
                bmh_pkg::OFS_UTIL_HI: s_next.rdata = s_reg.util[47:32];
                bmh_pkg::OFS_MATCH_LO: s_next.rdata = s_reg.match[15:0];
                bmh_pkg::OFS_MATCH_MID: s_next.rdata = s_reg.match[31:16];
                bmh_pkg::OFS_MATCH_HI: s_next.rdata = s_reg.match[47:32];
                default: s_next.rdata = 16'h0000;
            endcase
        end
        if (rd_hit(i_bus, bmh_pkg::OFS_MT_PEND)) begin
            s_next.mt_pend = 6'h00;
        end
        if (rd_hit(i_bus, bmh_pkg::OFS_HW_PEND)) begin
            s_next.tm_pend = 1'b0;
        end
        s_next.mt_pend = s_next.mt_pend | mt_new;
        s_next.tm_pend = s_next.tm_pend | tm_event;

        // Log writer; events arriving mid-entry merge into the next one
        unique case (s_reg.log_st)
            bmh_pkg::LOG_IDLE: begin
                if (s_reg.log_id != 16'h0000) begin
                    s_next.log.we = 1'b1;
                    s_next.log.addr = bmh_pkg::LOG_BASE
                                      + {10'h000, s_reg.log_ptr, 1'b0};
                    s_next.log.data = s_reg.log_id;
                    s_next.cur_iaw = s_reg.log_iaw;
                    s_next.log_id = 16'h0000;
                    s_next.log_st = bmh_pkg::LOG_ADDR;
                end
            end
            bmh_pkg::LOG_ADDR: begin
                s_next.log.we = 1'b1;
                s_next.log.addr = s_reg.log.addr + 16'h1;
                s_next.log.data = s_reg.cur_iaw;
                s_next.log_ptr = s_reg.log_ptr + 5'h1;
                s_next.log_st = bmh_pkg::LOG_IDLE;
            end
        endcase
        if (mt_new != 6'h00) begin
            s_next.log_id[8:3] = s_next.log_id[8:3] | mt_new;
            s_next.log_iaw = i_mon.status_addr;
        end
        if (tm_event) begin
            s_next.log_id[bmh_pkg::IIW_TM_BIT] = 1'b1;
            if (mt_new == 6'h00) begin
                s_next.log_iaw = 16'h0000;
            end
        end

        // One shared output for every group
        s_next.irq_n = !(|(s_next.mt_pend & s_next.mt_oe)
                         || (s_next.tm_pend && s_reg.hw_oe[bmh_pkg::HW_TM_BIT])
                         || i_bc_irq || i_rt_irq);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_reg <= '0;
            s_reg.base <= bmh_pkg::BASE_RESET;
            s_reg.irq_n <= 1'b1;
            s_reg.log_st <= bmh_pkg::LOG_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;
    assign o_irq_n = s_reg.irq_n;
    assign o_log = s_reg.log;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence log_id_word;
        o_log.we && s_reg.log_st == bmh_pkg::LOG_ADDR;
    endsequence
    sequence log_addr_word;
        o_log.we && s_reg.log_st == bmh_pkg::LOG_IDLE;
    endsequence

    AST_BASE_SOFT: assert property (
        i_mon.soft_reset && !wr_hit(i_bus, bmh_pkg::OFS_BASE)
        |=> $stable(s_reg.base))
        else $error("base moved on soft reset");
    AST_PTR_CLEAR: assert property (
        i_mon.soft_reset |=> s_reg.next_ptr == 16'h0000
                             && s_reg.last_ptr == 16'h0000)
        else $error("pointers not cleared");
    AST_LAST_LOAD: assert property (
        i_mon.msg_done && !i_mon.soft_reset
        |=> s_reg.last_ptr == $past(i_mon.first_addr)
            && s_reg.next_ptr == $past(i_mon.stack_ptr))
        else $error("pointers not loaded at message end");
    AST_NEXT_HOLD: assert property (
        !i_mon.msg_done && !i_mon.soft_reset |=> $stable(s_reg.next_ptr))
        else $error("next pointer changed without message end");
    AST_CAPTURE: assert property (
        tt_cmd == bmh_pkg::TT_CAPTURE
        |=> s_reg.util[15:0] == $past(s_reg.cnt[15:0]))
        else $error("capture failed");
    AST_LOAD: assert property (
        tt_cmd == bmh_pkg::TT_LOAD
        |=> s_reg.cnt[15:0] == $past(s_reg.util[15:0]))
        else $error("load failed");
    AST_PEND_SET: assert property (
        mt_new != 6'h00 |=> (s_reg.mt_pend & $past(mt_new)) == $past(mt_new))
        else $error("enabled event not pending");
    AST_PEND_CLR: assert property (
        rd_hit(i_bus, bmh_pkg::OFS_MT_PEND) && i_mon.events == 6'h00
        |=> s_reg.mt_pend == 6'h00 ##1 1'b1)
        else $error("pending not cleared by read");
    AST_DROP: assert property (
        s_reg.mt_pend == 6'h00 && mt_new == 6'h00 |=> s_reg.mt_pend == 6'h00)
        else $error("disabled event recorded");
    AST_IRQ: assert property (
        (s_reg.mt_pend & s_reg.mt_oe) != 6'h00 |-> !o_irq_n)
        else $error("interrupt output not asserted");
    AST_SUMMARY: assert property (
        rd_hit(i_bus, bmh_pkg::OFS_HW_PEND)
        |=> o_rdata[bmh_pkg::SUM_MT_BIT] == ($past(s_reg.mt_pend) != 6'h00))
        else $error("monitor summary wrong");
    AST_LOG_PAIR: assert property (
        log_id_word |=> log_addr_word
                        and (o_log.addr == $past(o_log.addr) + 16'h1))
        else $error("log entry not two words");

endmodule : bmh_regs

// ---- test/bmh_host_model.sv ----
/*
 * Host processor model for the bus monitor register bank: register
 * writes and reads on the plain strobe bus, and interrupt servicing.
 * Assumes the bank answers a read in the cycle after the strobe.
 */
`timescale 1ns/10ps
module bmh_host_model (
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    input wire logic i_irq_n,
    output bmh_pkg::bmh_bus_s o_bus
);

    initial o_bus = '0;

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles; released lines show inverted values so stale data hurts
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        o_bus <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
        #1;
        d = i_rdata;
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // Summary first; its value is kept since the read clears it
    task automatic service(output logic [15:0] hw, output logic [15:0] mt);
        rd(bmh_pkg::OFS_HW_PEND, hw);
        mt = 16'h0000;
        if (hw[bmh_pkg::SUM_MT_BIT] === 1'b1) begin
            rd(bmh_pkg::OFS_MT_PEND, mt);
        end
    endtask : service

endmodule : bmh_host_model

// ---- test/bus_monitor_host_regs_bench.sv ----
/*
 * Self-checking bench of the bus monitor host register bank.
 * Assumes one 100 MHz clock; the bench plays the monitor engine and
 * the other interrupt groups, the host model plays the processor.
 */
`timescale 1ns/10ps
module bus_monitor_host_regs_bench;

    typedef struct {
        logic [7:0] wa;
        logic [15:0] wd;
        logic [7:0] ra;
        logic [15:0] ex;
    } bmh_row_s;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    bmh_pkg::bmh_bus_s bus;
    bmh_pkg::bmh_mon_s mon = '0;
    logic bc_nz = 1'b0;
    logic rt_nz = 1'b0;
    logic bc_irq = 1'b0;
    logic rt_irq = 1'b0;
    logic [15:0] rdata;
    logic irq_n;
    bmh_pkg::bmh_log_s log_w;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int lp = 0;
    logic [31:0] exp_log[$];
    logic [31:0] got_log[$];
    logic [15:0] hw;
    logic [15:0] mt;
    bmh_row_s rows [11] = '{
        '{8'h2F, 16'h1234, 8'h2F, 16'h1234},
        '{8'h3D, 16'hA5A5, 8'h3D, 16'hA5A5},
        '{8'h3E, 16'h5A5A, 8'h3E, 16'h5A5A},
        '{8'h3F, 16'h0F0F, 8'h3F, 16'h0F0F},
        '{8'h40, 16'h1111, 8'h40, 16'h1111},
        '{8'h41, 16'h2222, 8'h41, 16'h2222},
        '{8'h42, 16'h3333, 8'h42, 16'h3333},
        '{8'h3A, 16'hFFFF, 8'h3A, 16'h0000},
        '{8'h31, 16'hFFFF, 8'h31, 16'h0000},
        '{8'h11, 16'h01FF, 8'h11, 16'h01F8},
        '{8'h50, 16'hFFFF, 8'h50, 16'h0000}
    };

    bmh_regs i_bmh_regs (.i_clk(clk), .i_arst_n(arst_n), .i_bus(bus),
        .i_mon(mon), .i_bc_pend_nz(bc_nz), .i_rt_pend_nz(rt_nz),
        .i_bc_irq(bc_irq), .i_rt_irq(rt_irq), .o_rdata(rdata),
        .o_irq_n(irq_n), .o_log(log_w));

    bmh_host_model i_bmh_host_model (.i_clk(clk), .i_rdata(rdata),
        .i_irq_n(irq_n), .o_bus(bus));

    always #5 clk = ~clk;

    // Log recorder and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (log_w.we === 1'b1) begin
            got_log.push_back({log_w.addr, log_w.data});
        end
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [15:0] e);
        logic [15:0] d;
        i_bmh_host_model.rd(a, d);
        check(n, {16'h0000, d}, {16'h0000, e});
    endtask : rdchk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_bmh_host_model.wr(a, d);
    endtask : wr

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            mon.tick <= 1'b1;
            @(posedge clk);
            mon.tick <= 1'b0;
        end
    endtask : tick

    task automatic pulse_ev(input int b, input logic [15:0] sa);
        logic [8:3] m;
        m = '0;
        m[b] = 1'b1;
        @(posedge clk);
        mon.events <= m;
        mon.status_addr <= sa;
        @(posedge clk);
        mon.events <= '0;
        settle(4);
    endtask : pulse_ev

    // Log slots advance two words at a time and wrap after 32 entries
    task automatic expect_log(input logic [15:0] id, input logic [15:0] sa);
        logic [15:0] a;
        a = bmh_pkg::LOG_BASE + 16'((lp % 32) * 2);
        exp_log.push_back({a, id});
        exp_log.push_back({a + 16'h0001, sa});
        lp++;
    endtask : expect_log

    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mon.mode = bmh_pkg::MODE_16;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rdchk("table", rows[i].ra, rows[i].ex);
        end
        // Master reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rdchk("base", bmh_pkg::OFS_BASE, 16'h00B0);
        for (int a = 8'h3D; a <= 8'h42; a++) begin
            rdchk("util_match", 8'(a), 16'h0000);
        end
        // Message completion, then monitor soft reset
        wr(bmh_pkg::OFS_BASE, 16'h4321);
        @(posedge clk);
        mon.msg_done <= 1'b1;
        mon.first_addr <= 16'h1111;
        mon.stack_ptr <= 16'h2222;
        @(posedge clk);
        mon.msg_done <= 1'b0;
        rdchk("last", bmh_pkg::OFS_LAST_PTR, 16'h1111);
        rdchk("next", bmh_pkg::OFS_NEXT_PTR, 16'h2222);
        @(posedge clk);
        mon.soft_reset <= 1'b1;
        repeat (2) @(posedge clk);
        mon.soft_reset <= 1'b0;
        rdchk("last0", bmh_pkg::OFS_LAST_PTR, 16'h0000);
        rdchk("next0", bmh_pkg::OFS_NEXT_PTR, 16'h0000);
        rdchk("base_kept", bmh_pkg::OFS_BASE, 16'h4321);
        // 16-bit time tag: load copies low word only, wraps at 16 bits
        wr(bmh_pkg::OFS_UTIL_LO, 16'hFFFE);
        wr(bmh_pkg::OFS_UTIL_MID, 16'h0005);
        wr(bmh_pkg::OFS_TT_CFG, {bmh_pkg::TT_LOAD, 14'h0000});
        rdchk("cnt_load", bmh_pkg::OFS_CNT_LO, 16'hFFFE);
        tick(3);
        rdchk("cnt16_lo", bmh_pkg::OFS_CNT_LO, 16'h0001);
        rdchk("cnt16_mid", bmh_pkg::OFS_CNT_MID, 16'h0000);
        // Clear command copies the utility word like a load
        wr(bmh_pkg::OFS_TT_CFG, {bmh_pkg::TT_CLEAR, 14'h0000});
        rdchk("cnt_clear", bmh_pkg::OFS_CNT_LO, 16'hFFFE);
        // 48-bit time tag: carry crosses both word boundaries
        mon.mode <= bmh_pkg::MODE_48;
        wr(bmh_pkg::OFS_UTIL_LO, 16'hFFFF);
        wr(bmh_pkg::OFS_UTIL_MID, 16'hFFFF);
        wr(bmh_pkg::OFS_UTIL_HI, 16'h0000);
        wr(bmh_pkg::OFS_TT_CFG, {bmh_pkg::TT_LOAD, 14'h0000});
        tick(1);
        rdchk("cnt48_lo", bmh_pkg::OFS_CNT_LO, 16'h0000);
        rdchk("cnt48_mid", bmh_pkg::OFS_CNT_MID, 16'h0000);
        rdchk("cnt48_hi", bmh_pkg::OFS_CNT_HI, 16'h0001);
        wr(bmh_pkg::OFS_TT_CFG, {bmh_pkg::TT_CAPTURE, 14'h0000});
        rdchk("cap_lo", bmh_pkg::OFS_UTIL_LO, 16'h0000);
        rdchk("cap_mid", bmh_pkg::OFS_UTIL_MID, 16'h0000);
        rdchk("cap_hi", bmh_pkg::OFS_UTIL_HI, 16'h0001);
        // Time match on the full 48-bit value
        wr(bmh_pkg::OFS_MATCH_LO, 16'h0002);
        wr(bmh_pkg::OFS_MATCH_HI, 16'h0001);
        wr(bmh_pkg::OFS_HW_IE, 16'h0040);
        wr(bmh_pkg::OFS_HW_OE, 16'h0040);
        tick(2);
        expect_log(16'h8000, 16'h0000);
        settle(3);
        check("irq_match", {31'h0, irq_n}, 32'h0);
        i_bmh_host_model.service(hw, mt);
        check("hw_match", {16'h0, hw}, 32'h0040);
        wr(bmh_pkg::OFS_HW_IE, 16'h0000);
        settle(2);
        check("irq_off", {31'h0, irq_n}, 32'h1);
        // Every monitor event, only bit 3 drives the output
        wr(bmh_pkg::OFS_MT_IE, 16'h01F8);
        wr(bmh_pkg::OFS_MT_OE, 16'h0008);
        for (int b = 3; b <= 8; b++) begin
            pulse_ev(b, 16'h0300 + 16'(b));
            expect_log(16'h0001 << b, 16'h0300 + 16'(b));
            check("irq_ev", {31'h0, irq_n}, {31'h0, b != 3});
            i_bmh_host_model.service(hw, mt);
            check("hw_sum", {16'h0, hw}, 32'h0002);
            check("mt_pend", {16'h0, mt}, 32'h1 << b);
            settle(2);
            check("irq_clr", {31'h0, irq_n}, 32'h1);
            rdchk("mt_clr", bmh_pkg::OFS_MT_PEND, 16'h0000);
        end
        // Event while disabled is forgotten once enabled again
        wr(bmh_pkg::OFS_MT_IE, 16'h01D8);
        pulse_ev(5, 16'h0555);
        wr(bmh_pkg::OFS_MT_IE, 16'h01F8);
        settle(2);
        rdchk("dropped", bmh_pkg::OFS_MT_PEND, 16'h0000);
        // Enough entries to wrap the log ring
        for (int k = 0; k < 27; k++) begin
            pulse_ev(3, 16'h0400 + 16'(k));
            expect_log(16'h0008, 16'h0400 + 16'(k));
        end
        rdchk("mt_accum", bmh_pkg::OFS_MT_PEND, 16'h0008);
        check("log_len", 32'(got_log.size()),
              32'(exp_log.size()));
        foreach (exp_log[i]) begin
            if (i < got_log.size()) begin
                check("log", got_log[i], exp_log[i]);
            end
        end
        // Other groups share the output and the summary bits
        settle(2);
        bc_irq <= 1'b1;
        settle(3);
        check("irq_bc", {31'h0, irq_n}, 32'h0);
        bc_irq <= 1'b0;
        rt_irq <= 1'b1;
        settle(3);
        check("irq_rt", {31'h0, irq_n}, 32'h0);
        rt_irq <= 1'b0;
        bc_nz <= 1'b1;
        rt_nz <= 1'b1;
        settle(3);
        check("irq_idle", {31'h0, irq_n}, 32'h1);
        rdchk("hw_bc_rt", bmh_pkg::OFS_HW_PEND, 16'h0005);
        give_verdict();
    end

endmodule : bus_monitor_host_regs_bench
